// ==== pkg/pipe_ctrl_pkg.sv ====
package pipe_ctrl_pkg;

    localparam int unsigned NUM_STAGES     = 4;
    localparam int unsigned PREFETCH_WORDS = 2;
    localparam int unsigned FP_LAT_DEFAULT = 0;
    localparam int unsigned FP_CNT_W       = 8;

    localparam logic [31:0] RESET_PC      = 32'h0000_0000;
    localparam logic [31:0] PC_STEP_FULL  = 32'h0000_0004;
    localparam logic [31:0] PC_STEP_COMP  = 32'h0000_0002;
    localparam logic [31:0] ILLEGAL_INSTR = 32'h0000_0000;

    localparam logic [6:0] OPC_OPIMM = 7'h13;
    localparam logic [6:0] OPC_OP    = 7'h33;
    localparam logic [6:0] OPC_LOAD  = 7'h03;
    localparam logic [6:0] OPC_STORE = 7'h23;
    localparam logic [6:0] OPC_JAL   = 7'h6f;
    localparam logic [6:0] OPC_JALR  = 7'h67;

    localparam logic [1:0] QUAD_0    = 2'h0;
    localparam logic [1:0] QUAD_1    = 2'h1;
    localparam logic [1:0] QUAD_2    = 2'h2;
    localparam logic [1:0] QUAD_FULL = 2'h3;

    typedef enum logic [1:0] {
        CTL_RUN    = 2'b01,
        CTL_FPWAIT = 2'b10
    } ctl_e;

endpackage

// ==== verilog/inorder_pipeline_hazard_control.sv ====
`timescale 1ns/100ps
module inorder_pipeline_hazard_control #(
    parameter int unsigned float_unit_latency_setting = pipe_ctrl_pkg::FP_LAT_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    output logic             instrReq,
    output logic [31:0]      instrAddr,
    input  wire logic        instrGnt,
    input  wire logic        instrRvalid,
    input  wire logic [31:0] instrRdata,
    output logic             idValid,
    output logic [31:0]      idInstr,
    output logic [31:0]      idPc,
    input  wire logic [4:0]  idRs1,
    input  wire logic [4:0]  idRs2,
    input  wire logic        idUseRs1,
    input  wire logic        idUseRs2,
    input  wire logic [4:0]  idRd,
    input  wire logic        idRegWe,
    input  wire logic        idIsJal,
    input  wire logic        idIsJalr,
    input  wire logic [31:0] idJumpTarget,
    input  wire logic        idIsLoad,
    input  wire logic        idIsFp,
    input  wire logic        idIsFpDivSqrt,
    input  wire logic [31:0] rfRdataA,
    input  wire logic [31:0] rfRdataB,
    output logic             exValid,
    output logic [4:0]       exRd,
    output logic [31:0]      exOperandA,
    output logic [31:0]      exOperandB,
    input  wire logic        exMultiCycleBusy,
    input  wire logic        exResultValid,
    input  wire logic [31:0] exResult,
    input  wire logic        exBranchTaken,
    input  wire logic [31:0] exBranchTarget,
    input  wire logic        fpResultValid,
    input  wire logic [31:0] fpResult,
    input  wire logic        loadValid,
    input  wire logic [31:0] loadData,
    output logic             stallId,
    output logic             stallEx,
    output logic             exWe,
    output logic [4:0]       exWaddr,
    output logic [31:0]      exWdata,
    output logic             wbWe,
    output logic [4:0]       wbWaddr,
    output logic [31:0]      wbWdata
);

    localparam bit LAT_EQ1 = (float_unit_latency_setting == 1);
    localparam bit LAT_GT1 = (float_unit_latency_setting > 1);
    localparam bit LAT_NZ  = (float_unit_latency_setting != 0);
    localparam logic [pipe_ctrl_pkg::FP_CNT_W-1:0] FP_CNT_INIT =
        pipe_ctrl_pkg::FP_CNT_W'(float_unit_latency_setting);

    typedef struct packed {
        pipe_ctrl_pkg::ctl_e                ctl;
        logic [pipe_ctrl_pkg::FP_CNT_W-1:0] fpCnt;
        logic [31:0]                        pc;
        logic [31:0]                        fetchAddr;
        logic [1:0][31:0]                   words;
        logic [1:0]                         cnt;
        logic                               outst;
        logic                               drop;
        logic                               idValid;
        logic [31:0]                        idInstr;
        logic [31:0]                        idPc;
        logic                               exValid;
        logic                               exWe;
        logic                               exLoad;
        logic                               exFp;
        logic [4:0]                         exRd;
        logic [31:0]                        exOpA;
        logic [31:0]                        exOpB;
        logic                               wbLoad;
        logic [4:0]                         wbRd;
        logic [4:0]                         fpRd;
        logic                               fpDiv;
        logic                               pendValid;
        logic [4:0]                         pendRd;
        logic [31:0]                        pendData;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic [15:0] loHalf;
    logic [15:0] hiHalf;
    logic        isComp;
    logic        avail;
    logic [31:0] rawInstr;
    logic        aluWrite;
    logic        fpA;
    logic        fpB;
    logic        ldW;
    logic        exStall;
    logic        idStall;
    logic        loadUse;
    logic        jalrHaz;
    logic        fpHaz;
    logic        idAdvance;
    logic        brTaken;
    logic        jumpTaken;
    logic        redirect;
    logic [31:0] target;
    logic        takeInstr;
    logic        pop;
    logic [1:0]  cntAfter;
    logic        push;

    function automatic logic [31:0] expandC(input logic [15:0] c);
        logic [11:0] immI;
        logic [11:0] immW;
        immI = {{6{c[12]}}, c[12], c[6:2]};
        immW = {5'h00, c[5], c[12:10], c[6], 2'h0};
        expandC = pipe_ctrl_pkg::ILLEGAL_INSTR;
        case ({c[15:13], c[1:0]})
            {3'h0, pipe_ctrl_pkg::QUAD_1}:
                expandC = {immI, c[11:7], 3'h0, c[11:7], pipe_ctrl_pkg::OPC_OPIMM};
            {3'h2, pipe_ctrl_pkg::QUAD_1}:
                expandC = {immI, 5'h00, 3'h0, c[11:7], pipe_ctrl_pkg::OPC_OPIMM};
            {3'h2, pipe_ctrl_pkg::QUAD_0}:
                expandC = {immW, 2'h1, c[9:7], 3'h2, 2'h1, c[4:2], pipe_ctrl_pkg::OPC_LOAD};
            {3'h6, pipe_ctrl_pkg::QUAD_0}:
                expandC = {5'h00, c[5], c[12], 2'h1, c[4:2], 2'h1, c[9:7], 3'h2,
                           c[11:10], c[6], 2'h0, pipe_ctrl_pkg::OPC_STORE};
            {3'h5, pipe_ctrl_pkg::QUAD_1}:
                expandC = {c[12], c[8], c[10:9], c[6], c[7], c[2], c[11], c[5:3],
                           c[12], {8{c[12]}}, 5'h00, pipe_ctrl_pkg::OPC_JAL};
            {3'h4, pipe_ctrl_pkg::QUAD_2}: begin
                if (c[6:2] != 5'h00) begin
                    expandC = {7'h00, c[6:2], c[12] ? c[11:7] : 5'h00, 3'h0, c[11:7],
                               pipe_ctrl_pkg::OPC_OP};
                end else begin
                    expandC = {12'h000, c[11:7], 3'h0, 4'h0, c[12],
                               pipe_ctrl_pkg::OPC_JALR};
                end
            end
            default: expandC = pipe_ctrl_pkg::ILLEGAL_INSTR;
        endcase
    endfunction

    // decode source matches a producer destination
    function automatic logic dependsOn(input logic [4:0] rd);
        dependsOn = (idUseRs1 && idRs1 == rd) || (idUseRs2 && idRs2 == rd);
    endfunction

    // youngest producer first; no write-through register file needed
    function automatic logic [31:0] fwd(input logic [4:0] rs, input logic [31:0] rf);
        if (aluWrite && s_q.exRd == rs) begin
            fwd = exResult;
        end else if ((fpA || fpB) && s_q.fpRd == rs) begin
            fwd = fpResult;
        end else if (ldW && s_q.wbRd == rs) begin
            fwd = loadData;
        end else if (s_q.pendValid && s_q.pendRd == rs) begin
            fwd = s_q.pendData;
        end else begin
            fwd = rf;
        end
    endfunction

    always_comb begin
        s_d = s_q;
        loHalf = s_q.pc[1] ? s_q.words[0][31:16] : s_q.words[0][15:0];
        hiHalf = s_q.pc[1] ? s_q.words[1][15:0] : s_q.words[0][31:16];
        isComp = loHalf[1:0] != pipe_ctrl_pkg::QUAD_FULL;
        // a full-width instruction at an odd half needs both buffered words
        avail = (s_q.pc[1] && !isComp) ? (s_q.cnt == 2'd2) : (s_q.cnt != 2'd0);
        rawInstr = isComp ? expandC(loHalf) : {hiHalf, loHalf};

        fpA = fpResultValid && LAT_GT1;
        fpB = fpResultValid && LAT_EQ1;
        aluWrite = s_q.exValid && s_q.exWe && !s_q.exLoad && exResultValid
                   && !(s_q.exFp && LAT_NZ);
        ldW = s_q.wbLoad && loadValid;
        exStall = exMultiCycleBusy || (fpA && aluWrite);

        loadUse = s_q.exValid && s_q.exLoad && s_q.exWe && dependsOn(s_q.exRd);
        jalrHaz = idIsJalr && idUseRs1 && s_q.exValid && s_q.exWe
                  && idRs1 == s_q.exRd;
        fpHaz = s_q.ctl == pipe_ctrl_pkg::CTL_FPWAIT && dependsOn(s_q.fpRd);
        idStall = exStall || loadUse || jalrHaz || fpHaz;

        brTaken = s_q.exValid && exBranchTaken && !exStall;
        idAdvance = s_q.idValid && !idStall && !brTaken;
        jumpTaken = idAdvance && (idIsJal || idIsJalr);
        redirect = brTaken || jumpTaken;
        target = brTaken ? exBranchTarget : idJumpTarget;

        // fetch buffer and aligner
        takeInstr = avail && (!s_q.idValid || idAdvance) && !redirect;
        pop = takeInstr && !(!s_q.pc[1] && isComp);
        cntAfter = s_q.cnt - {1'b0, pop};
        push = instrRvalid && !s_q.drop && !redirect;
        instrReq = !redirect && (!s_q.outst || instrRvalid)
                   && (cntAfter == 2'd0 || (cntAfter == 2'd1 && !push));
        if (pop) begin
            s_d.words[0] = s_q.words[1];
        end
        if (push) begin
            s_d.words[cntAfter[0]] = instrRdata;
        end
        s_d.cnt = cntAfter + {1'b0, push};
        if (takeInstr) begin
            s_d.pc = s_q.pc + (isComp ? pipe_ctrl_pkg::PC_STEP_COMP
                                      : pipe_ctrl_pkg::PC_STEP_FULL);
        end
        if (instrRvalid) begin
            s_d.outst = 1'b0;
            s_d.drop = 1'b0;
        end
        if (instrReq && instrGnt) begin
            s_d.outst = 1'b1;
            s_d.fetchAddr = s_q.fetchAddr + pipe_ctrl_pkg::PC_STEP_FULL;
        end

        // decode register
        if (takeInstr) begin
            s_d.idValid = 1'b1;
            s_d.idInstr = rawInstr;
            s_d.idPc = s_q.pc;
        end else if (idAdvance) begin
            s_d.idValid = 1'b0;
        end

        // redirect flushes fetch and decode; stale response is discarded
        if (redirect) begin
            s_d.pc = target;
            s_d.fetchAddr = {target[31:2], 2'h0};
            s_d.cnt = 2'd0;
            s_d.idValid = 1'b0;
            s_d.drop = s_q.outst && !instrRvalid;
        end

        // execute and write-back registers
        if (!exStall) begin
            s_d.exValid = idAdvance;
            s_d.exWe = idRegWe;
            s_d.exLoad = idIsLoad;
            s_d.exFp = idIsFp;
            s_d.exRd = idRd;
            s_d.exOpA = fwd(idRs1, rfRdataA);
            s_d.exOpB = fwd(idRs2, rfRdataB);
            s_d.wbLoad = s_q.exValid && s_q.exLoad && s_q.exWe;
            s_d.wbRd = s_q.exRd;
        end else begin
            s_d.wbLoad = 1'b0;
        end

        // float hazard window, counted in cycles of configured latency; a divide or square root holds it until fpResultValid
        case (s_q.ctl)
            pipe_ctrl_pkg::CTL_FPWAIT: begin
                if (s_q.fpDiv ? fpResultValid : (s_q.fpCnt <= 1)) begin
                    s_d.ctl = pipe_ctrl_pkg::CTL_RUN;
                end
                s_d.fpCnt = s_q.fpCnt - 1'b1;
            end
            default: s_d.ctl = pipe_ctrl_pkg::CTL_RUN;
        endcase
        if (idAdvance && idIsFp) begin
            s_d.fpRd = idRd;
            s_d.fpDiv = idIsFpDivSqrt;
            s_d.fpCnt = FP_CNT_INIT;
            if (LAT_NZ) begin
                s_d.ctl = pipe_ctrl_pkg::CTL_FPWAIT;
            end
        end

        // write-back port: load first, float parked for next free cycle
        if (!ldW) begin
            s_d.pendValid = 1'b0;
        end
        if (fpB && (ldW || s_q.pendValid)) begin
            s_d.pendValid = 1'b1;
            s_d.pendRd = s_q.fpRd;
            s_d.pendData = fpResult;
        end
        wbWe = ldW || s_q.pendValid || fpB;
        wbWaddr = ldW ? s_q.wbRd : (s_q.pendValid ? s_q.pendRd : s_q.fpRd);
        wbWdata = ldW ? loadData : (s_q.pendValid ? s_q.pendData : fpResult);

        // execute port shared with the float unit
        exWe = fpA || aluWrite;
        exWaddr = fpA ? s_q.fpRd : s_q.exRd;
        exWdata = fpA ? fpResult : exResult;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.ctl <= pipe_ctrl_pkg::CTL_RUN;
            s_q.pc <= pipe_ctrl_pkg::RESET_PC;
            s_q.fetchAddr <= {pipe_ctrl_pkg::RESET_PC[31:2], 2'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign instrAddr  = s_q.fetchAddr;
    assign idValid    = s_q.idValid;
    assign idInstr    = s_q.idInstr;
    assign idPc       = s_q.idPc;
    assign exValid    = s_q.exValid;
    assign exRd       = s_q.exRd;
    assign exOperandA = s_q.exOpA;
    assign exOperandB = s_q.exOpB;
    assign stallId    = idStall;
    assign stallEx    = exStall;

endmodule

// ==== testbench/instr_mem_model.sv ====
`timescale 1ns/100ps
module instr_mem_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        instrReq,
    input  wire logic [31:0] instrAddr,
    input  wire logic [1:0]  waitCycles,
    output logic             instrGnt,
    output logic             instrRvalid,
    output logic [31:0]      instrRdata
);
    logic [31:0] mem [64];
    logic [31:0] addr;
    logic [31:0] last;
    logic [1:0]  cnt;
    logic        pend;
    // one word in flight; a new grant may meet the returning word
    assign instrRvalid = pend && cnt == 2'h0;
    assign instrGnt    = !pend || instrRvalid;
    // idle data is the inverse of the last word, so a stale sample shows
    assign instrRdata  = instrRvalid ? mem[addr[7:2]] : ~last;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend <= 1'b0;
            cnt  <= 2'h0;
            last <= 32'h0;
        end else begin
            if (instrRvalid) last <= instrRdata;
            if (instrReq && instrGnt) begin
                pend <= 1'b1;
                addr <= instrAddr;
                cnt  <= waitCycles;
            end else if (instrRvalid) pend <= 1'b0;
            else if (pend) cnt <= cnt - 2'h1;
        end
    end
endmodule

// ==== testbench/pipe_hazard_sva.sv ====
`timescale 1ns/100ps
module pipe_hazard_sva #(
    parameter int unsigned float_unit_latency_setting = 0
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        idValid,
    input wire logic [4:0]  idRs1,
    input wire logic        idUseRs1,
    input wire logic [4:0]  idRd,
    input wire logic        idRegWe,
    input wire logic        idIsJalr,
    input wire logic        idIsLoad,
    input wire logic        idIsFp,
    input wire logic        idIsFpDivSqrt,
    input wire logic        exValid,
    input wire logic [4:0]  exRd,
    input wire logic        exMultiCycleBusy,
    input wire logic        exResultValid,
    input wire logic [31:0] exResult,
    input wire logic        exBranchTaken,
    input wire logic        fpResultValid,
    input wire logic [31:0] fpResult,
    input wire logic        loadValid,
    input wire logic [31:0] loadData,
    input wire logic        stallId,
    input wire logic        stallEx,
    input wire logic        exWe,
    input wire logic [4:0]  exWaddr,
    input wire logic [31:0] exWdata,
    input wire logic        wbWe,
    input wire logic [31:0] wbWdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic adv;
    // a taken branch flushes decode, so the instruction there never reaches execute
    assign adv = idValid && !stallId && !(exValid && exBranchTaken);
    AST_MULTI_STALL: assert property (exValid && exMultiCycleBusy |-> stallEx && stallId)
        else $error("multi-cycle op did not stall");
    AST_EX_HOLD: assert property (exValid && stallEx |=> exValid && $stable(exRd))
        else $error("execute stage moved while stalled");
    AST_EX_WRITE: assert property (exValid && exResultValid && !fpResultValid |-> exWe
        && exWaddr == exRd && exWdata == exResult) else $error("execute result not written");
    AST_FP_WINS: assert property (float_unit_latency_setting > 1 && fpResultValid
        |-> exWe && exWdata == fpResult) else $error("float result lost the port");
    AST_FP_CONFLICT: assert property (float_unit_latency_setting > 1 && fpResultValid
        && exValid && exResultValid |-> stallEx) else $error("port conflict without stall");
    AST_LOAD_WB: assert property (loadValid |-> wbWe && wbWdata == loadData)
        else $error("load data not written back");
    AST_LOAD_USE: assert property (adv && idIsLoad && idRegWe ##1 idValid && idUseRs1
        && idRs1 == $past(idRd) |-> stallId) else $error("load-use without stall");
    AST_JALR: assert property (adv && idRegWe ##1 idValid && idIsJalr && idUseRs1
        && idRs1 == $past(idRd) |-> stallId) else $error("jalr hazard without stall");
    // the repetition is a literal, so this one only speaks for latency 2
    AST_FP_STALL: assert property (float_unit_latency_setting == 2 && adv && idIsFp
        && !idIsFpDivSqrt && idRegWe ##1 idValid && idUseRs1 && idRs1 == $past(idRd)
        |-> stallId [*2]) else $error("float dependency stall too short");
    cover property (idValid && stallId && !exMultiCycleBusy);
    cover property (fpResultValid && exResultValid);
    cover property (loadValid);
endmodule

// ==== testbench/inorder_pipeline_hazard_control_tb.sv ====
`timescale 1ns/100ps
module inorder_pipeline_hazard_control_tb;
    localparam int unsigned LAT = 2;
    localparam logic [31:0] NOP = 32'h00000013;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        instrReq, instrGnt, instrRvalid, idValid, exValid, stallId, stallEx, exWe, wbWe;
    logic        idUseRs1, idUseRs2, idRegWe, idIsJal, idIsJalr, idIsLoad, idIsFp, idIsFpDivSqrt;
    logic        exMultiCycleBusy = 1'b0, exResultValid = 1'b0, exBranchTaken = 1'b0;
    logic        fpResultValid = 1'b0, loadValid = 1'b0, exRegWe, wbLd;
    logic [1:0]  waitCycles = 2'h0;
    logic [2:0]  cls, exCls, busyN, fpN;
    logic [4:0]  exRd, exWaddr, wbWaddr, idRs1, idRs2, idRd;
    logic [31:0] instrAddr, instrRdata, idInstr, idPc, exOperandA, exOperandB, exWdata, wbWdata;
    logic [31:0] idJumpTarget, exResult = 32'h0, rfRdataA = 32'h40, rfRdataB = 32'h0;
    logic [31:0] exBranchTarget = 32'h40, fpResult = 32'hf0, loadData = 32'h1234;
    logic [31:0] stalls, wrongPath, seenC;
    int          mismatches = 0;
    int          samples_checked = 0;

    always #2 clk = ~clk;
    inorder_pipeline_hazard_control #(.float_unit_latency_setting(LAT)) dut (.*);
    instr_mem_model imem (.*);

    // decoder stand-in; x0 is never marked as used or written
    assign idRs1         = idInstr[19:15];
    assign idRs2         = idInstr[24:20];
    assign idRd          = idInstr[11:7];
    assign idIsJal       = idInstr[6:0] == pipe_ctrl_pkg::OPC_JAL;
    assign idIsJalr      = idInstr[6:0] == pipe_ctrl_pkg::OPC_JALR;
    assign idIsLoad      = idInstr[6:0] == pipe_ctrl_pkg::OPC_LOAD;
    assign idIsFp        = idInstr[6:0] == 7'h53;
    assign idIsFpDivSqrt = idIsFp && (idInstr[31:27] == 5'h03 || idInstr[31:27] == 5'h0b);
    assign idUseRs1      = !idIsJal && idRs1 != 5'h0;
    assign idUseRs2      = (idIsFp || idInstr[6:0] == pipe_ctrl_pkg::OPC_OP) && idRs2 != 5'h0;
    assign idRegWe       = idRd != 5'h0 && idInstr[6:0] != 7'h63;
    assign idJumpTarget  = idIsJalr ? rfRdataA : idPc + 32'h10;
    assign cls = idIsLoad ? 3'h1 : idIsFpDivSqrt ? 3'h3 : idIsFp ? 3'h2
               : (idInstr[6:0] == pipe_ctrl_pkg::OPC_OP && idInstr[25]) ? 3'h4
               : idInstr[6:0] == 7'h63 ? 3'h5 : 3'h0;

    // execute-side units: mul busy 3 cycles, float divide 6, other float LAT
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exCls <= 3'h0;
            busyN <= 3'h0;
            fpN   <= 3'h0;
            wbLd  <= 1'b0;
        end else begin
            wbLd <= exValid && !stallEx && exCls == 3'h1;
            if (!stallEx) exCls <= (idValid && !stallId) ? cls : 3'h0;
            if (!stallEx) exRegWe <= idRegWe;
            busyN <= (idValid && !stallId && cls == 3'h4) ? 3'h3 : busyN - 3'(busyN != 3'h0);
            if (exValid && !stallEx && exCls[2:1] == 2'h1) fpN <= exCls[0] ? 3'h6 : 3'(LAT);
            else fpN <= fpN - 3'(fpN != 3'h0);
        end
    end
    always @(negedge clk) begin
        exMultiCycleBusy <= busyN != 3'h0;
        exResultValid    <= exValid && exRegWe && (exCls == 3'h0 || exCls == 3'h4) && busyN == 3'h0;
        exResult         <= exOperandA + 32'h1;
        loadValid        <= wbLd;
        fpResultValid    <= fpN == 3'h1;
        exBranchTaken    <= exValid && exCls == 3'h5;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic load(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
        for (int i = 0; i < 64; i++) imem.mem[i] = NOP;
        imem.mem[0] = w0;
        imem.mem[1] = w1;
        imem.mem[2] = w2;
    endtask
    // every run starts from a fresh reset, so a reset in mid-traffic is exercised too
    task automatic run(input int n);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        stalls = 32'h0;
        wrongPath = 32'h0;
        seenC = 32'h0;
        repeat (n) begin
            @(negedge clk);
            stalls += 32'(idValid && stallId);
            wrongPath += 32'(exWe && exWaddr == 5'h09);
            if (idValid && idPc == 32'h42) seenC = idInstr;
        end
    endtask

    task automatic s_fwd;
        load(32'h00500093, 32'h00108113, NOP);
        run(30);
        check("forward stalls", stalls, 32'h0);
    endtask
    task automatic s_load_use;
        load(32'h00002083, 32'h00108113, NOP);
        run(30);
        check("load-use stalls", stalls, 32'h1);
    endtask
    task automatic s_jalr;
        load(32'h00500093, 32'h00008067, NOP);
        run(30);
        check("jalr stalls", stalls, 32'h1);
    endtask
    task automatic s_jump_branch;
        load(32'h0100006f, 32'h00000493, NOP);
        imem.mem[4] = 32'h00000063;
        imem.mem[5] = 32'h00000493;
        imem.mem[16] = 32'h44014401;
        waitCycles = 2'h1;
        run(60);
        waitCycles = 2'h0;
        check("wrong-path writes", wrongPath, 32'h0);
        check("expanded c.li", seenC, 32'h00000413);
    endtask
    task automatic s_mul;
        load(32'h021081b3, 32'h00100293, NOP);
        run(30);
        check("multi-cycle stalls", stalls, 32'h3);
    endtask
    task automatic s_fp;
        // producer writes x1 so the next float op really depends on it
        load(32'h003100d3, 32'h00308153, NOP);
        run(30);
        check("float dependency stalls", stalls, 32'(LAT));
        load(32'h00310053, 32'h00100293, 32'h00100313);
        imem.mem[3] = 32'h00100393;
        run(30);
        check("float port conflict stalls", stalls, 32'h1);
        load(32'h183100d3, 32'h00308153, NOP);
        run(40);
        check("divide wait", {31'h0, stalls >= 32'h5}, 32'h1);
    endtask

    initial begin
        s_fwd();
        s_load_use();
        s_jalr();
        s_jump_branch();
        s_mul();
        s_fp();
        finish_test();
    end
    initial begin
        #20000;
        mismatches++;
        finish_test();
    end
endmodule

bind inorder_pipeline_hazard_control pipe_hazard_sva #(
    .float_unit_latency_setting(float_unit_latency_setting)
) chk (.*);
